//--- tb_tbm_engine.sv
/* self-checking bench of tbm_engine
   assumes the bench models the row store with one cycle read latency */
`timescale 1ns/10ps
module tb_tbm_engine;
  import tbm_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    tbm_part_type      p;
    tbm_row_type       d;
  } tbm_exp_type;
  logic              clk = 1'b0, rst = 1'b1, go = 1'b0, hit = 1'b0, clr = 1'b0, arm = 1'b0;
  logic [ADDR_W-1:0] hit_a = 9'h000, addr;
  logic              go_o, flag, rd_en, wr_en, cwr;
  logic [31:0]       seed = 32'h00000045;
  tbm_cfg_type       cfg = '0;
  tbm_row_type       cache = '0, rdd = '0, wd, cdat, mem [512];
  tbm_row_type       cq [$];
  tbm_part_type      part;
  tbm_exp_type       q [$];
  int                error_cnt = 0, total_checks = 0, rd_cnt = 0, cyc = 0;

  tbm_engine dut (.ref_clk_i(clk), .sys_rst_i(rst), .cfg_i(cfg), .operation_go_i(go),
    .cache_i(cache), .lookup_hit_i(hit), .lookup_addr_i(hit_a), .rd_data_i(rdd),
    .row_dropped_clr_i(clr), .operation_go_o(go_o), .row_dropped_flag_o(flag),
    .rd_en_o(rd_en), .wr_en_o(wr_en), .row_addr_o(addr), .wr_part_o(part),
    .wr_data_o(wd), .cache_wr_o(cwr), .cache_data_o(cdat));

  always #12.5 clk = ~clk;

  function logic [31:0] rnd();
    for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
    return seed;
  endfunction : rnd

  function tbm_row_type mk();
    tbm_row_type r;
    r = {rnd(), rnd(), 2'h1, rnd(), rnd()};
    r.tg[1] = seed[5];
    return r;
  endfunction : mk

  task chk(input logic [129:0] s, input logic [129:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t mismatch %h vs %h", $time, s, e);
    end
  endtask : chk

  task wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // row store model, stale read data inverted
  always @(posedge clk) begin
    if (rd_en) begin
      rdd <= mem[addr];
      cq.push_back(mem[addr]);
      rd_cnt++;
    end else rdd <= ~rdd;
    if (wr_en && part.tcam) {mem[addr].key, mem[addr].tg} <= {wd.key, wd.tg};
    if (wr_en && part.action) mem[addr].action <= wd.action;
    if (wr_en && part.count) mem[addr].count <= wd.count;
    hit <= arm && rd_en;
    hit_a <= addr;
    if (hit) arm <= 1'b0;
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  always @(negedge clk) if (!rst) begin
    tbm_exp_type e;
    if (cwr && cq.size() == 0) chk(1'b1, 1'b0);
    else if (cwr) chk(cdat, cq.pop_front());
    if (wr_en && q.size() == 0) chk(1'b1, 1'b0);
    else if (wr_en) begin
      e = q.pop_front();
      chk(addr, e.a);
      chk(part, e.p);
      chk({wd.key, wd.tg}, {e.d.key, e.d.tg});
      if (part.action) chk(wd.action, e.d.action);
      if (part.count) chk(wd.count, e.d.count);
    end
  end

  task cmd(input int op, input int b, input int n, input int s, input tbm_part_type sk,
           input logic ig);
    int lo, i, t;
    logic up, mv;
    up = (op == OP_MOVE_UP);
    mv = up || op == OP_MOVE_DN;
    @(posedge clk);
    lo = up ? b - s : b + s;
    for (int j = 0; j <= n; j++) begin
      i = (op == OP_MOVE_DN) ? n - j : j;
      if (op == OP_INIT) q.push_back({ADDR_W'(b + j), ~sk, cache});
      else if (mv && lo + i >= 0) q.push_back({ADDR_W'(lo + i), ~sk, mem[b + i]});
    end
    for (int j = 0; j <= n; j++)
      if (mv && !sk.tcam && (b + j < lo || b + j > lo + n))
        q.push_back({ADDR_W'(b + j), PART_TCAM, 130'h0});
    cfg <= {OP_W'(op), ADDR_W'(b), ADDR_W'(n), ADDR_W'(s), sk, ig};
    go <= 1'b1;
    @(posedge clk);
    // go held on while busy must be ignored
    cfg.base <= 9'h1F0;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (t = 0; t < 2000 && go_o === 1'b1; t++) @(negedge clk);
    chk(t < 2000, 1'b1);
    repeat (3) @(posedge clk);
    chk(q.size(), 0);
    chk(cq.size(), 0);
  endtask : cmd

  initial begin
    for (int i = 0; i < 512; i++) mem[i] = mk();
    cache = mk();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cmd(OP_INIT, 'h0FF, 'h2, 'h0, PART_NONE, 1'b0);
    cache <= mk();
    cmd(OP_INIT, 'h028, 'h0, 'h0, 3'h2, 1'b0);
    cmd(OP_MOVE_DN, 'h00A, 'h2, 'h1, PART_NONE, 1'b0);
    cmd(OP_MOVE_UP, 'h001, 'h2, 'h3, PART_NONE, 1'b0);
    @(negedge clk);
    chk(flag, 1'b1);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(negedge clk);
    chk(flag, 1'b0);
    cmd(OP_MOVE_DN, 'h100, 'h0, 'h1, PART_TCAM, 1'b0);
    cmd(OP_MOVE_UP, 'h03C, 'h1, 'h1, 3'h5, 1'b0);
    for (int k = 0; k < 2; k++) begin
      rd_cnt = 0;
      arm <= 1'b1;
      cmd(OP_MOVE_DN, 'h014, 'h0, 'h1, PART_NONE, k[0]);
      chk(rd_cnt, 2 - k);
    end
    for (int o = 0; o < 2; o++) cmd(o, 'h01E, 'h0, 'h0, PART_NONE, 1'b0);
    wrap_up();
  end
endmodule : tb_tbm_engine

//--- tbm_engine.sv
/*
 * Block move and block initialization engine of the classification
 * match engine: walks a block of rows, copies them through the shared
 * cache, invalidates vacated TCAM rows and flags dropped rows.
 * Assumes a row store with one cycle read latency, write taking effect
 * on the cycle the write strobe is seen, and a lookup hit report giving
 * the row that was hit.
 */
`timescale 1ns/10ps
module tbm_engine
  import tbm_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire tbm_cfg_type       cfg_i,
  input  wire logic              operation_go_i,
  input  wire tbm_row_type       cache_i,
  input  wire logic              lookup_hit_i,
  input  wire logic [ADDR_W-1:0] lookup_addr_i,
  input  wire tbm_row_type       rd_data_i,
  input  wire logic              row_dropped_clr_i,
  output logic                   operation_go_o,
  output logic                   row_dropped_flag_o,
  output logic                   rd_en_o,
  output logic                   wr_en_o,
  output logic      [ADDR_W-1:0] row_addr_o,
  output tbm_part_type           wr_part_o,
  output tbm_row_type            wr_data_o,
  output logic                   cache_wr_o,
  output tbm_row_type            cache_data_o
);

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_READ  = 8'h02,
    ST_WAIT  = 8'h04,
    ST_LOAD  = 8'h08,
    ST_WRITE = 8'h10,
    ST_NEXT  = 8'h20,
    ST_INV   = 8'h40,
    ST_INIT  = 8'h80
  } tbm_state_type;

  tbm_state_type     state_q, state_d;
  tbm_cfg_type       cfg_q, cfg_d;
  logic [ADDR_W-1:0] idx_q, idx_d;
  logic              busy_q, busy_d;
  logic              drop_q, drop_d;
  logic              rd_q, rd_d;
  logic              wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  tbm_part_type      part_q, part_d;
  tbm_row_type       wdat_q, wdat_d;
  logic              cwr_q, cwr_d;
  tbm_row_type       cache_q, cache_d;

  logic [ADDR_W-1:0] src_row;
  logic [ADDR_W-1:0] dst_row;
  logic              dst_neg;
  logic              covered;
  logic              is_up;
  logic              is_down;
  logic              last_row;
  logic              restart;
  logic              drop_set;
  tbm_part_type      parts_on;
  logic [ADDR_W-1:0] idx_step;
  logic [ADDR_W-1:0] idx_start;
  logic [ADDR_W-1:0] last_idx;
  tbm_row_type       inv_row;
  logic [ADDR_W-1:0] shift_sel;
  logic              block_end;
  logic              go_take;
  logic              go_move;
  logic              go_init;

  tbm_row_addr u_row_addr (
    .base_i        (cfg_q.base),
    .idx_i         (idx_q),
    .shift_i       (shift_sel),
    .count_i       (cfg_q.block_count),
    .up_i          (is_up),
    .src_o         (src_row),
    .dst_o         (dst_row),
    .dst_neg_o     (dst_neg),
    .src_covered_o (covered)
  );

  function automatic logic is_move(input logic [OP_W-1:0] op);
    is_move = (op == OP_MOVE_UP) || (op == OP_MOVE_DN);
  endfunction : is_move

  // end of a walk: index has reached its stop value
  function automatic logic at_block_end(input logic [ADDR_W-1:0] idx,
                                        input logic [ADDR_W-1:0] stop);
    at_block_end = idx == stop;
  endfunction : at_block_end

  // init writes rows in place, so no shift
  assign shift_sel = (cfg_q.op == OP_INIT) ? ADDR_ZERO : cfg_q.shift_distance;
  assign block_end = at_block_end(idx_q, cfg_q.block_count);
  // go seen while busy is dropped silently
  assign go_take   = operation_go_i && (state_q == ST_IDLE);
  assign go_move   = is_move(cfg_i.op);
  assign go_init   = cfg_i.op == OP_INIT;
  assign is_up     = cfg_q.op == OP_MOVE_UP;
  assign is_down   = cfg_q.op == OP_MOVE_DN;
  assign parts_on  = ~cfg_q.skip;
  // down walks from the top of the block so no row is overwritten early
  assign idx_start = (cfg_i.op == OP_MOVE_DN) ? cfg_i.block_count : ADDR_ZERO;
  assign last_idx  = is_down ? ADDR_ZERO : cfg_q.block_count;
  assign last_row  = at_block_end(idx_q, last_idx);
  assign idx_step  = is_down ? idx_q - ADDR_ONE : idx_q + ADDR_ONE;
  // a hit on the row in flight would be lost from the copied counter
  assign restart   = lookup_hit_i && (lookup_addr_i == src_row)
                     && !cfg_q.ignore_lookup_restarts;
  assign drop_set  = (state_q == ST_WRITE) && !restart && dst_neg;

  always_comb begin
    inv_row        = cache_q;
    inv_row.key    = KEY_CLEAR;
    inv_row.tg     = TG_INVALID;
  end

  always_comb begin
    state_d = state_q;
    cfg_d   = cfg_q;
    idx_d   = idx_q;
    busy_d  = busy_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    addr_d  = addr_q;
    part_d  = PART_NONE;
    wdat_d  = wdat_q;
    cwr_d   = 1'b0;
    cache_d = cache_q;
    unique case (state_q)
      ST_IDLE: begin
        if (go_take) begin
          cfg_d  = cfg_i;
          idx_d  = idx_start;
          busy_d = 1'b1;
          if (go_move) begin
            state_d = ST_READ;
          end else if (go_init) begin
            state_d = ST_INIT;
          end else begin
            // single-entry copies are handled elsewhere
            busy_d = 1'b0;
          end
        end
      end
      ST_READ: begin
        rd_d    = 1'b1;
        addr_d  = src_row;
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        state_d = restart ? ST_READ : ST_LOAD;
      end
      ST_LOAD: begin
        cache_d = rd_data_i;
        cwr_d   = 1'b1;
        state_d = restart ? ST_READ : ST_WRITE;
      end
      ST_WRITE: begin
        if (restart) begin
          state_d = ST_READ;
        end else begin
          // rows pushed below zero are simply not written
          wr_d    = !dst_neg;
          addr_d  = dst_row;
          part_d  = dst_neg ? PART_NONE : parts_on;
          wdat_d  = cache_q;
          state_d = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (!last_row) begin
          idx_d   = idx_step;
          state_d = ST_READ;
        end else if (cfg_q.skip.tcam) begin
          busy_d  = 1'b0;
          state_d = ST_IDLE;
        end else begin
          idx_d   = ADDR_ZERO;
          state_d = ST_INV;
        end
      end
      ST_INV: begin
        // vacated rows only; rows now holding moved data are kept
        wr_d   = !covered;
        addr_d = src_row;
        part_d = covered ? PART_NONE : PART_TCAM;
        wdat_d = inv_row;
        idx_d  = idx_q + ADDR_ONE;
        if (block_end) begin
          busy_d  = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_INIT: begin
        // address range runs into default rows when asked
        wr_d   = 1'b1;
        addr_d = src_row;
        part_d = parts_on;
        wdat_d = cache_i;
        idx_d  = idx_q + ADDR_ONE;
        if (block_end) begin
          busy_d  = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        busy_d  = 1'b0;
        state_d = ST_IDLE;
      end
    endcase
  end

  // set wins over a clear in the same cycle
  assign drop_d = drop_set || (drop_q && !row_dropped_clr_i);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
      drop_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= busy_d;
      drop_q  <= drop_d;
    end
  end

  // read and cache-write strobes last one cycle; the row write strobe stays on across init walks but drops for covered rows in invalidate walks
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      cwr_q   <= 1'b0;
      part_q  <= PART_NONE;
    end else begin
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      cwr_q   <= cwr_d;
      part_q  <= part_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg_q   <= '0;
      idx_q   <= ADDR_ZERO;
      addr_q  <= ADDR_ZERO;
      wdat_q  <= '0;
      cache_q <= '0;
    end else begin
      cfg_q   <= cfg_d;
      idx_q   <= idx_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      cache_q <= cache_d;
    end
  end

  assign operation_go_o     = busy_q;
  assign row_dropped_flag_o = drop_q;
  assign rd_en_o            = rd_q;
  assign wr_en_o            = wr_q;
  assign row_addr_o         = addr_q;
  assign wr_part_o          = part_q;
  assign wr_data_o          = wdat_q;
  assign cache_wr_o         = cwr_q;
  assign cache_data_o       = cache_q;

endmodule : tbm_engine

//--- tbm_engine_chk.sv
/* port checker of tbm_engine
   assumes one clock, synchronous active-high reset */
`timescale 1ns/10ps
module tbm_chk
  import tbm_pkg::*;
(
  input wire logic         ref_clk_i,
  input wire logic         sys_rst_i,
  input wire tbm_cfg_type  cfg_i,
  input wire logic         operation_go_i,
  input wire logic         row_dropped_clr_i,
  input wire logic         operation_go_o,
  input wire logic         row_dropped_flag_o,
  input wire logic         rd_en_o,
  input wire logic         wr_en_o,
  input wire tbm_part_type wr_part_o,
  input wire logic         cache_wr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire go_take = operation_go_i && !operation_go_o;
  wire op_run  = cfg_i.op inside {OP_MOVE_UP, OP_MOVE_DN, OP_INIT};

  a_go_start: assert property (go_take && op_run |=> operation_go_o)
    else $error("busy not raised after go");
  a_noop_idle: assert property (go_take && !op_run |=> !operation_go_o)
    else $error("busy raised for a no-op code");
  a_wr_busy: assert property (wr_en_o |-> operation_go_o || $past(operation_go_o))
    else $error("row write while idle");
  a_rd_busy: assert property (rd_en_o |-> operation_go_o)
    else $error("row read while idle");
  a_rd_pulse: assert property (rd_en_o |=> !rd_en_o)
    else $error("read strobe longer than one cycle");
  a_part_idle: assert property (!wr_en_o |-> wr_part_o == PART_NONE)
    else $error("write parts set without a write");
  a_flag_hold: assert property (row_dropped_flag_o && !row_dropped_clr_i |=> row_dropped_flag_o)
    else $error("sticky flag lost without clear");
  a_flag_cause: assert property ($rose(row_dropped_flag_o) |-> $past(operation_go_o))
    else $error("flag set outside a move");
  a_cache_busy: assert property (cache_wr_o |-> operation_go_o)
    else $error("cache written while idle");
endmodule : tbm_chk

bind tbm_engine tbm_chk u_chk (.ref_clk_i, .sys_rst_i, .cfg_i, .operation_go_i,
  .row_dropped_clr_i, .operation_go_o, .row_dropped_flag_o, .rd_en_o, .wr_en_o,
  .wr_part_o, .cache_wr_o);

//--- tbm_pkg.sv
/*
 * Constants, command codes and carrier types of the block move and
 * block initialization engine.
 * Assumes one clock domain and a row store split into TCAM, action and
 * hit counter parts that share one row address.
 */
package tbm_pkg;

  localparam int ADDR_W   = 9;
  localparam int KEY_W    = 64;
  localparam int TG_W     = 2;
  localparam int ACT_W    = 32;
  localparam int CNT_W    = 32;
  localparam int OP_W     = 3;

  // default rows start right after the regular rows
  localparam logic [ADDR_W-1:0] REG_ROWS   = 9'h100;
  localparam logic [TG_W-1:0]   TG_INVALID = 2'h0;
  localparam logic [KEY_W-1:0]  KEY_CLEAR  = 64'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 9'h001;

  localparam logic [OP_W-1:0] OP_TO_RAM   = 3'h0;
  localparam logic [OP_W-1:0] OP_TO_CACHE = 3'h1;
  localparam logic [OP_W-1:0] OP_MOVE_UP  = 3'h2;
  localparam logic [OP_W-1:0] OP_MOVE_DN  = 3'h3;
  localparam logic [OP_W-1:0] OP_INIT     = 3'h4;

  typedef struct packed {
    logic [KEY_W-1:0] key;
    logic [TG_W-1:0]  tg;
    logic [ACT_W-1:0] action;
    logic [CNT_W-1:0] count;
  } tbm_row_type;

  typedef struct packed {
    logic tcam;
    logic action;
    logic count;
  } tbm_part_type;

  typedef struct packed {
    logic [OP_W-1:0]   op;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] block_count;
    logic [ADDR_W-1:0] shift_distance;
    tbm_part_type      skip;
    logic              ignore_lookup_restarts;
  } tbm_cfg_type;

  localparam tbm_part_type PART_NONE = 3'h0;
  localparam tbm_part_type PART_TCAM = 3'h4;

endpackage : tbm_pkg

//--- tbm_row_addr.sv
/*
 * Row address arithmetic: source and destination of one row of a block,
 * whether the destination falls below row zero, and whether the source
 * row lies inside the destination range of the whole block.
 * Purely combinational; the caller registers the results it drives out.
 */
`timescale 1ns/10ps
module tbm_row_addr
  import tbm_pkg::*;
(
  input  wire logic [ADDR_W-1:0] base_i,
  input  wire logic [ADDR_W-1:0] idx_i,
  input  wire logic [ADDR_W-1:0] shift_i,
  input  wire logic [ADDR_W-1:0] count_i,
  input  wire logic              up_i,
  output logic      [ADDR_W-1:0] src_o,
  output logic      [ADDR_W-1:0] dst_o,
  output logic                   dst_neg_o,
  output logic                   src_covered_o
);

  logic signed [ADDR_W+1:0] base_s;
  logic signed [ADDR_W+1:0] src_s;
  logic signed [ADDR_W+1:0] shift_s;
  logic signed [ADDR_W+1:0] dst_s;
  logic signed [ADDR_W+1:0] lo_s;
  logic signed [ADDR_W+1:0] hi_s;

  assign base_s  = signed'({2'h0, base_i});
  assign shift_s = signed'({2'h0, shift_i});
  assign src_s   = base_s + signed'({2'h0, idx_i});
  // move-up lowers the address, move-down raises it
  assign dst_s   = up_i ? src_s - shift_s : src_s + shift_s;
  assign lo_s    = up_i ? base_s - shift_s : base_s + shift_s;
  assign hi_s    = lo_s + signed'({2'h0, count_i});

  assign src_o         = src_s[ADDR_W-1:0];
  assign dst_o         = dst_s[ADDR_W-1:0];
  assign dst_neg_o     = dst_s < 0;
  assign src_covered_o = (src_s >= lo_s) && (src_s <= hi_s);

endmodule : tbm_row_addr
